// *** verilog/serdes_pkg.sv ***
`default_nettype none

// Shared constants, carriers and helpers for the pin control block.
package serdes_pkg;

  // System clock period and the bench pixel clock period, both in ns.
  localparam int CLK_PERIOD_NS = 8;
  localparam int PIX_CLK_PERIOD_NS = 80;

  // Half period of the regenerated pixel clock in system cycles, rounded down.
  localparam int PIX_HALF_CYCLES = PIX_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] PIX_HALF_LAST = 4'(PIX_HALF_CYCLES - 1);

  // Least data-enable pulse width, in pixel clocks, passed with the filter on.
  localparam int FILTER_MIN_CLOCKS = 3;
  localparam logic [1:0] FILTER_LAST = 2'(FILTER_MIN_CLOCKS - 1);

  // Link configuration codes for the control-signal filter.
  localparam logic [1:0] LINK_FILTER_OFF = 2'h0;
  localparam logic [1:0] LINK_FILTER_ON = 2'h1;

  // Width of the parallel pixel bus.
  localparam int PIXEL_W = 24;

  // One parallel word: pixel data plus its data-enable control bit.
  typedef struct packed {
    logic [PIXEL_W-1:0] pixel;
    logic dataEnable;
  } pix_word_s;

  // Serializer configuration register, loaded over the control bus.
  typedef struct packed {
    logic swingOvrEn;
    logic swingOvrVal;
    logic deemphEn;
    logic strobeOvrEn;
    logic strobeOvrVal;
  } cfg_s;

  // Values after reset; all but WORD_RESET also load during power-down.
  localparam pix_word_s WORD_RESET = '0;
  localparam cfg_s CFG_RESET = '0;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [3:0] HALF_RESET = 4'h0;

  // Picks the rising edge when sel is 1 and the falling edge when sel is 0.
  function automatic logic pickEdge(input logic rise, input logic fall, input logic sel);
    pickEdge = sel ? rise : fall;
  endfunction : pickEdge

endpackage : serdes_pkg

`default_nettype wire

// *** verilog/pix_buffer.sv ***
`default_nettype none

// Two-entry buffer; entry 0 is the head and feeds the output directly.
module pix_buffer
  import serdes_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic flush, // Synchronous clear, empties the buffer.
  input wire pix_word_s inWord, // Word offered by the filling side.
  input wire logic inValid, // Filling side offers a word.
  output var logic inReady, // Buffer can take a word.
  output var pix_word_s outWord, // Head word.
  output var logic outValid, // Head word is valid.
  input wire logic outReady // Draining side takes the head word.
);

  pix_word_s entry_reg [2]; // Storage, index 0 is the head.
  pix_word_s entry_next [2]; // Next storage.
  logic [1:0] count_reg; // Words held, 0 to 2.
  logic [1:0] count_next; // Next word count.
  logic valid_reg; // Head valid, kept in a flip-flop so the output needs no gate.
  logic valid_next; // Next head valid.
  logic push; // A word enters this cycle.
  logic pop; // A word leaves this cycle.

  // Computes the next storage; a pop shifts entry 1 into the head.
  always_comb begin
    push = inValid && (count_reg != 2'h2);
    pop = outReady && (count_reg != 2'h0);
    entry_next[0] = entry_reg[0];
    entry_next[1] = entry_reg[1];
    count_next = count_reg;
    if (flush) begin
      count_next = COUNT_RESET;
    end else begin
      if (pop) begin
        entry_next[0] = entry_reg[1];
      end
      // The new word lands in the first slot free after the pop.
      if (push) begin
        if ((count_reg == 2'h0) || ((count_reg == 2'h1) && pop)) begin
          entry_next[0] = inWord;
        end else begin
          entry_next[1] = inWord;
        end
      end
      count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
    // The head is valid whenever the buffer will hold at least one word.
    valid_next = (count_next != COUNT_RESET);
  end

  // Registers storage and count.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      entry_reg[0] <= WORD_RESET;
      entry_reg[1] <= WORD_RESET;
      count_reg <= COUNT_RESET;
      valid_reg <= 1'b0;
    end else begin
      entry_reg <= entry_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
    end
  end

  // Flags follow the count; ready is combinational from the held count.
  assign inReady = (count_reg != 2'h2);
  assign outValid = valid_reg;
  assign outWord = entry_reg[0];

endmodule : pix_buffer

`default_nettype wire

// *** verilog/serdes_pin_control.sv ***
`default_nettype none

module serdes_pin_control
  import serdes_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic power_down_n, // Power-down pin, low powers down.
  input wire logic pixClkIn, // Pixel clock pin of the serializer.
  input wire logic [PIXEL_W-1:0] pixDataIn, // Parallel pixel data pins.
  input wire logic dataEnableIn, // Data-enable control input pin.
  input wire logic strobe_edge_select, // 1 rising, 0 falling strobe edge.
  input wire logic swing_select, // 1 large swing, 0 small swing.
  input wire logic deemphasis_ctrl, // 1 resistor fitted, 0 pin floating.
  input wire logic idle_output_state_select, // Idle level of pixel clock and data-enable outputs in power-down.
  input wire logic [1:0] link_config, // Control-filter setting.
  input wire logic cfgWrite, // Control-bus write strobe, one cycle.
  input wire cfg_s cfgData, // Control-bus write data.
  output var cfg_s cfgReadback, // Configuration register contents.
  output var logic srcReady, // Capture buffer has room.
  output var pix_word_s txWord, // Word towards the serial link.
  output var logic txValid, // Word towards the link is valid.
  input wire logic txReady, // Link takes the word.
  output var logic serialOutP, // Serial output, true leg.
  output var logic serialOutN, // Serial output, inverted leg.
  output var logic pllRunning, // Serializer PLL is running.
  output var logic swingLarge, // Large output swing selected.
  output var logic deemphOn, // Output de-emphasis enabled.
  input wire pix_word_s rxWord, // Word received from the link.
  input wire logic rxValid, // Received word is valid.
  output var logic rxReady, // Received word consumed, one cycle.
  output var logic pixel_clock_out, // Regenerated pixel clock.
  output var logic data_enable_out, // Filtered data-enable output.
  output var logic [PIXEL_W-1:0] pixDataOut // Parallel pixel data output.
);

  localparam int SYNC_W = PIXEL_W + 9; // Width of the pin synchroniser.

  logic [SYNC_W-1:0] sync1_reg; // First synchroniser stage.
  logic [SYNC_W-1:0] sync2_reg; // Second synchroniser stage.
  logic pixClkS; // Synchronised pixel clock.
  logic [PIXEL_W-1:0] pixDataS; // Synchronised pixel data.
  logic dataEnableS; // Synchronised data enable.
  logic powerUpS; // Synchronised power_down_n.
  logic strobeS; // Synchronised strobe_edge_select.
  logic swingS; // Synchronised swing_select.
  logic deemphS; // Synchronised deemphasis_ctrl.
  logic idleS; // Synchronised idle_output_state_select.
  logic [1:0] linkCfgS; // Synchronised link_config.

  logic clkPrev_reg; // Pixel clock one cycle ago.
  cfg_s cfg_reg; // Configuration register.
  cfg_s cfg_next; // Next configuration.
  logic strobeEff; // Effective serializer strobe edge.
  logic capture; // Serializer strobe edge seen.
  logic swing_reg; // Registered swing choice.
  logic swing_next; // Next swing choice.
  logic deemph_reg; // Registered de-emphasis enable.
  logic deemph_next; // Next de-emphasis enable.
  logic serP_reg; // Serial true leg.
  logic serN_reg; // Serial inverted leg.
  logic serP_next; // Next true leg.
  logic serN_next; // Next inverted leg.
  logic pll_reg; // PLL run flag.
  logic srcReady_reg; // Registered buffer room flag.
  logic bufInReady; // Buffer room, combinational.
  pix_word_s bufOutWord; // Buffer head word.
  logic bufOutValid; // Buffer head valid.

  logic [3:0] half_reg; // Half-period counter of the output clock.
  logic [3:0] half_next; // Next half-period count.
  logic pclk_reg; // Output pixel clock.
  logic pclk_next; // Next output pixel clock.
  logic de_reg; // Output data enable.
  logic de_next; // Next output data enable.
  logic [PIXEL_W-1:0] dout_reg; // Output pixel data.
  logic [PIXEL_W-1:0] dout_next; // Next output pixel data.
  logic [1:0] filt_reg; // Words with enable differing from output.
  logic [1:0] filt_next; // Next filter count.
  logic rxReady_reg; // Consume pulse.
  logic rxReady_next; // Next consume pulse.
  logic toggle; // Output clock toggles this cycle.
  logic strobeOut; // Output strobe edge this cycle.

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {pixClkIn, pixDataIn, dataEnableIn, power_down_n, strobe_edge_select,
                    swing_select, deemphasis_ctrl, idle_output_state_select, link_config};
      sync2_reg <= sync1_reg;
    end
  end

  // Splits the second stage into named pins.
  assign {pixClkS, pixDataS, dataEnableS, powerUpS, strobeS, swingS, deemphS, idleS, linkCfgS} = sync2_reg;

  // Picks the strobe edge; the register override wins over the pin.
  always_comb begin
    strobeEff = cfg_reg.strobeOvrEn ? cfg_reg.strobeOvrVal : strobeS;
    capture = pickEdge(pixClkS && !clkPrev_reg, !pixClkS && clkPrev_reg, strobeEff);
  end

  // Computes the serializer control state.
  always_comb begin
    cfg_next = cfg_reg;
    if (cfgWrite) begin
      cfg_next = cfgData;
    end
    swing_next = cfg_reg.swingOvrEn ? cfg_reg.swingOvrVal : swingS;
    deemph_next = cfg_reg.deemphEn || deemphS;
    // Normal operation idles the link as a differential one.
    serP_next = 1'b1;
    serN_next = 1'b0;
    if (!powerUpS) begin
      cfg_next = CFG_RESET;
      serN_next = 1'b1;
      swing_next = 1'b0;
      deemph_next = 1'b0;
    end
  end

  // Registers the serializer control state.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clkPrev_reg <= 1'b0;
      cfg_reg <= CFG_RESET;
      swing_reg <= 1'b0;
      deemph_reg <= 1'b0;
      serP_reg <= 1'b1;
      serN_reg <= 1'b1;
      pll_reg <= 1'b0;
      srcReady_reg <= 1'b0;
    end else begin
      clkPrev_reg <= pixClkS;
      cfg_reg <= cfg_next;
      swing_reg <= swing_next;
      deemph_reg <= deemph_next;
      serP_reg <= serP_next;
      serN_reg <= serN_next;
      pll_reg <= powerUpS;
      srcReady_reg <= bufInReady && powerUpS;
    end
  end

  // Captured words wait here until the link takes them.
  pix_buffer captureBuf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(!powerUpS),
    .inWord({pixDataS, dataEnableS}),
    .inValid(capture && powerUpS),
    .inReady(bufInReady),
    .outWord(bufOutWord),
    .outValid(bufOutValid),
    .outReady(txReady && powerUpS)
  );

  // Output clock toggles at the end of each half period.
  always_comb begin
    toggle = (half_reg == PIX_HALF_LAST);
    strobeOut = toggle && pickEdge(!pclk_reg, pclk_reg, strobeS);
  end

  // Computes the deserializer outputs and the control filter.
  always_comb begin
    half_next = toggle ? HALF_RESET : 4'(half_reg + 4'h1);
    pclk_next = toggle ? !pclk_reg : pclk_reg;
    de_next = de_reg;
    dout_next = dout_reg;
    filt_next = filt_reg;
    rxReady_next = 1'b0;
    if (!powerUpS) begin
      half_next = HALF_RESET;
      pclk_next = idleS;
      de_next = idleS;
      dout_next = '0;
      filt_next = COUNT_RESET;
    end else if (strobeOut && rxValid) begin
      rxReady_next = 1'b1;
      dout_next = rxWord.pixel;
      if (linkCfgS == LINK_FILTER_ON) begin
        // A new level passes only once it has held for the least width.
        if (rxWord.dataEnable != de_reg) begin
          if (filt_reg == FILTER_LAST) begin
            de_next = rxWord.dataEnable;
            filt_next = COUNT_RESET;
          end else begin
            filt_next = 2'(filt_reg + 2'h1);
          end
        end else begin
          filt_next = COUNT_RESET;
        end
      end else begin
        de_next = rxWord.dataEnable;
        filt_next = COUNT_RESET;
      end
    end
  end

  // Registers the deserializer outputs.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      half_reg <= HALF_RESET;
      pclk_reg <= 1'b0;
      de_reg <= 1'b0;
      dout_reg <= '0;
      filt_reg <= COUNT_RESET;
      rxReady_reg <= 1'b0;
    end else begin
      half_reg <= half_next;
      pclk_reg <= pclk_next;
      de_reg <= de_next;
      dout_reg <= dout_next;
      filt_reg <= filt_next;
      rxReady_reg <= rxReady_next;
    end
  end

  // Outputs come straight from flip-flops; txWord and txValid from the buffer's.
  assign cfgReadback = cfg_reg;
  assign srcReady = srcReady_reg;
  assign txWord = bufOutWord;
  assign txValid = bufOutValid;
  assign serialOutP = serP_reg;
  assign serialOutN = serN_reg;
  assign pllRunning = pll_reg;
  assign swingLarge = swing_reg;
  assign deemphOn = deemph_reg;
  assign rxReady = rxReady_reg;
  assign pixel_clock_out = pclk_reg;
  assign data_enable_out = de_reg;
  assign pixDataOut = dout_reg;

endmodule : serdes_pin_control

`default_nettype wire

// *** bench/serdes_pin_control_assertions.sv ***
`default_nettype none

// Watches the pin control block at its ports only.
module serdes_pin_control_assertions
  import serdes_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic rstn, // Reset.
  input wire logic power_down_n, // Power pin.
  input wire logic strobe_edge_select, // Edge pin.
  input wire logic swing_select, // Swing pin.
  input wire logic deemphasis_ctrl, // Emphasis pin.
  input wire logic idle_output_state_select, // Idle pin.
  input wire logic cfgWrite, // Write strobe.
  input wire cfg_s cfgData, // Write data.
  input wire cfg_s cfgReadback, // Register.
  input wire pix_word_s txWord, // Link word.
  input wire logic txValid, // Link valid.
  input wire logic txReady, // Link ready.
  input wire logic serialOutP, // True leg.
  input wire logic serialOutN, // Inverted leg.
  input wire logic pllRunning, // PLL state.
  input wire logic swingLarge, // Swing.
  input wire logic deemphOn, // Emphasis.
  input wire logic rxReady, // Word taken.
  input wire logic pixel_clock_out, // Pixel clock.
  input wire logic [PIXEL_W-1:0] pixDataOut // Pixel data.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // The pin has been low or high long enough to pass the synchronisers.
  sequence downHeld;
    !power_down_n [*6];
  endsequence
  sequence upHeld;
    power_down_n [*6];
  endsequence
  serial_down_a: assert property (downHeld |-> serialOutP && serialOutN)
    else $error("serial legs not high in power-down");
  down_regs_a: assert property (downHeld |-> !pllRunning && cfgReadback == CFG_RESET && !txValid)
    else $error("power-down did not clear state");
  idle_out_a: assert property ((!power_down_n && $stable(idle_output_state_select)) [*6] |->
    pixel_clock_out == idle_output_state_select && pixDataOut == '0)
    else $error("idle outputs wrong in power-down");
  serial_run_a: assert property (upHeld |-> serialOutP && !serialOutN && pllRunning)
    else $error("serial not running when powered");
  cfg_take_a: assert property (upHeld ##0 cfgWrite |=> cfgReadback == $past(cfgData))
    else $error("config write not taken");
  swing_sel_a: assert property ((power_down_n && !cfgWrite && $stable(swing_select)) [*6] |->
    swingLarge == (cfgReadback.swingOvrEn ? cfgReadback.swingOvrVal : swing_select))
    else $error("swing choice wrong");
  deemph_sel_a: assert property ((power_down_n && !cfgWrite && $stable(deemphasis_ctrl)) [*6] |->
    deemphOn == (deemphasis_ctrl || cfgReadback.deemphEn))
    else $error("de-emphasis choice wrong");
  rx_edge_a: assert property ((power_down_n && $stable(strobe_edge_select)) [*7] ##0 $changed(pixDataOut)
    |-> pixel_clock_out == strobe_edge_select)
    else $error("data changed on wrong clock edge");
  rx_pulse_a: assert property (rxReady |-> pixel_clock_out != $past(pixel_clock_out) ##1 !rxReady)
    else $error("word taken off the clock edge");
  tx_hold_a: assert property (power_down_n [*4] ##0 (txValid && !txReady) |=> txValid && $stable(txWord))
    else $error("link word not held under stall");
endmodule : serdes_pin_control_assertions

bind serdes_pin_control serdes_pin_control_assertions u_checks (
  .clk_sys, .rstn, .power_down_n, .strobe_edge_select, .swing_select, .deemphasis_ctrl,
  .idle_output_state_select, .cfgWrite, .cfgData, .cfgReadback, .txWord, .txValid, .txReady,
  .serialOutP, .serialOutN, .pllRunning, .swingLarge, .deemphOn, .rxReady, .pixel_clock_out, .pixDataOut
);

`default_nettype wire

// *** bench/link_partner.sv ***
`default_nettype none

// Far end of the link: takes serializer words and feeds numbered words back.
module link_partner
  import serdes_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic rstn, // Reset.
  input wire logic stall, // Hold off the serializer.
  input wire logic rxGap, // Withhold received words.
  input wire logic rxDe, // Enable bit to send.
  output var logic txReady, // Link word taken.
  output var pix_word_s rxWord, // Word offered.
  output var logic rxValid, // Offer valid.
  input wire logic rxReady // Offer consumed.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIXEL_W-1:0] rxCnt; // Pixel value on offer.
  // Slow only on command, so no word is ever lost here.
  assign txReady = !stall;
  assign rxValid = !rxGap;
  // Lines show the inverse outside an offer, never a stale word.
  assign rxWord = rxValid ? {rxCnt, rxDe} : ~{rxCnt, rxDe};
  // Moves to the next word once the current one is consumed.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxCnt <= '0;
    end else if (rxValid && rxReady) begin
      rxCnt <= rxCnt + 24'h0001;
    end
  end
endmodule : link_partner

`default_nettype wire

// *** bench/tb_serdes_pin_control.sv ***
`default_nettype none

// Self-checking bench for the pin control block.
module tb_serdes_pin_control
  import serdes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, rstn = 1'h0, power_down_n = 1'h0, pixClkIn = 1'h0, dataEnableIn = 1'h0;
  logic strobe_edge_select = 1'h1, swing_select = 1'h0, deemphasis_ctrl = 1'h0, idle_output_state_select = 1'h0;
  logic cfgWrite = 1'h0, stall = 1'h0, rxGap = 1'h0, rxDe = 1'h0, pixRun = 1'h0, mon = 1'h0, srcEdge = 1'h1;
  logic txReady, rxValid, rxReady, srcReady, txValid, serialOutP, serialOutN, pllRunning;
  logic swingLarge, deemphOn, pixel_clock_out, data_enable_out, txSeen, rxSeen;
  logic [PIXEL_W-1:0] pixDataIn = '0, srcVal = 24'h0001, pixDataOut, lastTx, lastRx;
  logic [1:0] link_config = 2'h0; // Filter setting.
  logic [3:0] phase = 4'h0; // Position in the pixel period.
  cfg_s cfgData = CFG_RESET, cfgReadback;
  pix_word_s txWord, rxWord;
  int num_errors = 0, n_checks = 0;

  serdes_pin_control u_dut (.clk_sys, .rstn, .power_down_n, .pixClkIn, .pixDataIn, .dataEnableIn,
    .strobe_edge_select, .swing_select, .deemphasis_ctrl, .idle_output_state_select, .link_config,
    .cfgWrite, .cfgData, .cfgReadback, .srcReady, .txWord, .txValid, .txReady, .serialOutP, .serialOutN,
    .pllRunning, .swingLarge, .deemphOn, .rxWord, .rxValid, .rxReady, .pixel_clock_out,
    .data_enable_out, .pixDataOut);
  link_partner u_link (.clk_sys, .rstn, .stall, .rxGap, .rxDe, .txReady, .rxWord, .rxValid, .rxReady);

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  // Pixel clock of ten cycles; good data lands two cycles after the other edge.
  // The source places data for srcEdge, the edge that the serializer is set to use.
  always @(posedge clk_sys) begin
    if (pixRun) begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
      if (phase == 4'h0 || phase == 4'h5) pixClkIn <= ~pixClkIn;
      if ((phase == 4'h2 || phase == 4'h7) && pixClkIn == srcEdge) pixDataIn <= '0;
      if ((phase == 4'h2 || phase == 4'h7) && pixClkIn != srcEdge) begin
        pixDataIn <= srcVal;
        // Enable follows a slow data bit, so it changes at most twice in 130 clocks.
        dataEnableIn <= srcVal[8];
        srcVal <= srcVal + 24'h0002;
      end
    end
  end

  // Follows words on both sides; the first word after a pause only seeds it.
  always @(posedge clk_sys) begin
    if (!mon) begin
      txSeen <= 1'h0;
      rxSeen <= 1'h0;
    end else begin
      if (txValid && txReady) begin
        check(txWord.pixel[0], 1'h1);
        check(txWord.dataEnable, txWord.pixel[8]);
        if (txSeen) check(txWord.pixel, lastTx + 24'h0002);
        lastTx <= txWord.pixel;
        txSeen <= 1'h1;
      end
      if (rxReady) begin
        check(pixel_clock_out, strobe_edge_select);
        if (rxSeen) check(pixDataOut, lastRx + 24'h0001);
        lastRx <= pixDataOut;
        rxSeen <= 1'h1;
      end
    end
  end

  task automatic check(input logic [PIXEL_W:0] seen, input logic [PIXEL_W:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Writes the configuration register with a one-cycle strobe.
  task automatic wr(input cfg_s v);
    cfgData <= v;
    cfgWrite <= 1'h1;
    cyc(1);
    cfgWrite <= 1'h0;
    cyc(3);
  endtask : wr

  // Power up, write, then power down: state clears and idle levels follow the pin.
  task automatic t_power();
    power_down_n <= 1'h1;
    cyc(8);
    check({serialOutP, serialOutN, pllRunning}, 3'h5);
    wr(5'h15);
    check(cfgReadback, 5'h15);
    power_down_n <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      idle_output_state_select <= i[0];
      cyc(8);
      check({pixel_clock_out, data_enable_out}, {2{i[0]}});
      check({serialOutP, serialOutN, pllRunning, txValid}, 4'hc);
      wr(5'h1f);
      check(cfgReadback, CFG_RESET);
    end
    power_down_n <= 1'h1;
    pixRun <= 1'h1;
    cyc(8);
    mon <= 1'h1;
  endtask : t_power

  // Every pin combination, then the register override of both.
  task automatic t_swing();
    for (int i = 0; i < 4; i++) begin
      swing_select <= i[0];
      deemphasis_ctrl <= i[1];
      cyc(6);
      // Swing follows bit 0 of i and de-emphasis bit 1.
      check({swingLarge, deemphOn}, {i[0], i[1]});
      wr({1'h1, ~i[0], 1'h1, 2'h0});
      check({swingLarge, deemphOn}, {~i[0], 1'h1});
      wr(CFG_RESET);
    end
  endtask : t_swing

  // Both capture edges by pin, then rising by register while the pin asks falling.
  task automatic t_edge();
    for (int s = 0; s < 3; s++) begin
      mon <= 1'h0;
      strobe_edge_select <= s[0];
      srcEdge <= s[0] | s[1];
      // The override stays on for the rest of the run; the receive side keeps the pin.
      if (s == 2) wr({3'h0, 2'h3});
      cyc(30);
      mon <= 1'h1;
      cyc(200);
      check(txSeen && rxSeen, 1'h1);
    end
  endtask : t_edge

  // Short stalls lose nothing; a long stall fills the buffer until it refuses.
  task automatic t_fill();
    stall <= 1'h1;
    rxGap <= 1'h1;
    cyc(12);
    stall <= 1'h0;
    rxGap <= 1'h0;
    cyc(40);
    mon <= 1'h0;
    stall <= 1'h1;
    cyc(60);
    check({srcReady, txValid}, 2'h1);
    pixRun <= 1'h0;
    stall <= 1'h0;
    cyc(10);
    check({srcReady, txValid}, 2'h2);
    pixRun <= 1'h1;
    mon <= 1'h1;
  endtask : t_fill

  // An enable pulse of len words; then a quiet spell of 130 clocks.
  task automatic pulse(input int len, input logic exp);
    logic hit;
    hit = 1'h0;
    @(posedge clk_sys iff rxReady);
    rxDe <= 1'h1;
    repeat (len) begin
      @(posedge clk_sys iff rxReady);
      hit |= data_enable_out;
    end
    rxDe <= 1'h0;
    repeat (130) begin
      @(posedge clk_sys iff rxReady);
      hit |= data_enable_out;
    end
    check(hit, exp);
  endtask : pulse

  // Filter off passes one word; filter on drops two and passes three.
  task automatic t_filter();
    link_config <= LINK_FILTER_OFF;
    cyc(20);
    pulse(1, 1'h1);
    link_config <= LINK_FILTER_ON;
    cyc(20);
    pulse(2, 1'h0);
    pulse(3, 1'h1);
  endtask : t_filter

  // Cuts a hang short.
  initial begin
    cyc(20000);
    num_errors++;
    finish_test();
  end

  initial begin
    cyc(20);
    rstn <= 1'h1;
    cyc(5);
    t_power();
    t_swing();
    t_edge();
    t_fill();
    t_filter();
    finish_test();
  end
endmodule : tb_serdes_pin_control

`default_nettype wire
